//--- src/dcs_top.sv
// dma channel control and status for two channels
// assumes a register port with one-cycle strobes and read data one cycle later
`timescale 1ns/1ps
module dcs_top
  import dcs_pkg::*;
#(
  parameter int NCH = 2 // channel count
)(
  input  wire logic              core_clk,            // system clock
  input  wire logic              reset,               // sync reset, active high
  input  wire logic              standby,             // standby: initialise like reset
  input  wire logic [DCS_AW-1:0] reg_addr,            // register index
  input  wire logic [31:0]       reg_wdata,           // write data
  input  wire logic              reg_wr,              // write strobe
  input  wire logic              reg_rd,              // read strobe
  output logic      [31:0]       reg_rdata,           // read data, cycle after strobe
  input  wire logic [NCH-1:0]    ext_request,         // external request lines
  input  wire logic              serial_rx_full_req,  // serial receive-full
  input  wire logic              serial_tx_empty_req, // serial transmit-empty
  input  wire logic              nmi,                 // nmi event pulse
  input  wire logic              addr_error,          // address error event pulse
  input  wire logic              unit_done,           // datapath finished a unit (after write)
  output logic      [NCH-1:0]    grant,               // channel allowed to run a unit
  output logic      [NCH-1:0]    burst_mode,          // bus-mode select per channel
  output logic      [NCH-1:0]    single_addr,         // address-mode select per channel
  output logic      [NCH-1:0]    transfer_end_irq,    // end interrupt per channel
  output logic      [7:0]        vec0,                // channel 0 vector
  output logic      [7:0]        vec1                 // channel 1 vector
);
  logic [15:0]          channel_control [NCH];
  logic [7:0]           end_vector      [NCH];
  logic [1:0]           req_source      [NCH];
  logic [DCS_CNT_W-1:0] transfer_count  [NCH];
  logic [3:0]           operation_register;
  logic [NCH-1:0]       te_seen;
  logic [1:0]           oper_seen;
  logic [NCH-1:0]       pending;
  logic [NCH-1:0]       may_run;
  logic [NCH-1:0]       next_grant;
  logic                 rr_ch1_first;
  logic                 busy;
  logic                 init;

  assign init = reset | standby;

  function automatic logic hit(input logic [DCS_AW-1:0] a);
    hit = reg_wr && (reg_addr == a);
  endfunction

  // ----------------------------------------------------------------
  // per-channel registers and detectors
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : ch
      dcs_req_if rq ();
      logic [DCS_AW-1:0] a_ctrl;
      logic [DCS_AW-1:0] a_vec;
      logic [DCS_AW-1:0] a_rsel;
      logic [DCS_AW-1:0] a_cnt;
      logic              unit_end;
      assign a_ctrl   = (g == 0) ? DCS_CTRL0 : DCS_CTRL1;
      assign a_vec    = (g == 0) ? DCS_VEC0  : DCS_VEC1;
      assign a_rsel   = (g == 0) ? DCS_RSEL0 : DCS_RSEL1;
      assign a_cnt    = (g == 0) ? DCS_CNT0  : DCS_CNT1;
      assign unit_end = unit_done && grant[g];

      assign rq.detect_edge = channel_control[g][DCS_B_DET];
      assign rq.polarity    = channel_control[g][DCS_B_POL];
      assign rq.source      = req_source[g];
      assign rq.auto_mode   = channel_control[g][DCS_B_AUTO];
      assign rq.take        = unit_end;
      assign pending[g]     = rq.pending;

      dcs_req_detect u_det (
        .core_clk            (core_clk),
        .reset               (init),
        .ext_request         (ext_request[g]),
        .serial_rx_full_req  (serial_rx_full_req),
        .serial_tx_empty_req (serial_tx_empty_req),
        .rq                  (rq)
      );

      // channel control; end flag set wins over a software clear
      always_ff @(posedge core_clk) begin
        if (init) begin
          channel_control[g] <= DCS_CTRL_RST;
        end else begin
          if (hit(a_ctrl)) begin
            channel_control[g] <= (reg_wdata[15:0] & DCS_CTRL_WMASK) |
              (channel_control[g] & ~DCS_CTRL_WMASK &
               {16{~(te_seen[g] & ~reg_wdata[DCS_B_TE])}});
          end
          if (unit_end && transfer_count[g] == DCS_CNT_W'(1)) begin
            channel_control[g][DCS_B_TE] <= 1'b1;
          end
        end
      end

      // read-1 tracking for the clear handshake
      always_ff @(posedge core_clk) begin
        if (init) begin
          te_seen[g] <= 1'b0;
        end else if (reg_rd && reg_addr == a_ctrl) begin
          te_seen[g] <= channel_control[g][DCS_B_TE];
        end else if (hit(a_ctrl)) begin
          te_seen[g] <= 1'b0;
        end
      end

      always_ff @(posedge core_clk) begin
        if (init) begin
          end_vector[g] <= DCS_VEC_RST;
        end else if (hit(a_vec)) begin
          end_vector[g] <= reg_wdata[7:0];
        end
      end

      always_ff @(posedge core_clk) begin
        if (init) begin
          req_source[g] <= DCS_RSEL_RST;
        end else if (hit(a_rsel)) begin
          req_source[g] <= reg_wdata[1:0];
        end
      end

      always_ff @(posedge core_clk) begin
        if (init) begin
          transfer_count[g] <= '0;
        end else if (unit_end) begin
          transfer_count[g] <= transfer_count[g] - DCS_CNT_W'(1);
        end else if (hit(a_cnt)) begin
          transfer_count[g] <= reg_wdata[DCS_CNT_W-1:0];
        end
      end

      assign may_run[g] = channel_control[g][DCS_B_EN] & ~channel_control[g][DCS_B_TE] &
                          operation_register[DCS_B_ME] & ~operation_register[DCS_B_NMI] &
                          ~operation_register[DCS_B_AE];
      assign burst_mode[g]       = channel_control[g][DCS_B_BMODE];
      assign single_addr[g]      = channel_control[g][DCS_B_AMODE];
      assign transfer_end_irq[g] = channel_control[g][DCS_B_TE] &
                                   channel_control[g][DCS_B_IE];
    end
  endgenerate

  assign vec0 = end_vector[0];
  assign vec1 = end_vector[1];

  // ----------------------------------------------------------------
  // operation register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (init) begin
      operation_register <= DCS_OPER_RST;
    end else begin
      if (hit(DCS_OPER)) begin
        operation_register[DCS_B_PRI] <= reg_wdata[DCS_B_PRI];
        operation_register[DCS_B_ME]  <= reg_wdata[DCS_B_ME];
        if (oper_seen[0] && !reg_wdata[DCS_B_NMI]) begin
          operation_register[DCS_B_NMI] <= 1'b0;
        end
        if (oper_seen[1] && !reg_wdata[DCS_B_AE]) begin
          operation_register[DCS_B_AE] <= 1'b0;
        end
      end
      if (nmi) begin
        operation_register[DCS_B_NMI] <= 1'b1;
      end
      if (addr_error) begin
        operation_register[DCS_B_AE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (init) begin
      oper_seen <= 2'h0;
    end else if (reg_rd && reg_addr == DCS_OPER) begin
      oper_seen <= {operation_register[DCS_B_AE], operation_register[DCS_B_NMI]};
    end else if (hit(DCS_OPER)) begin
      oper_seen <= 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // arbitration: grant held until the unit finishes unless an enable drops, so an nmi lets it complete
  // ----------------------------------------------------------------
  always_comb begin
    next_grant = '0;
    if (operation_register[DCS_B_PRI] && rr_ch1_first) begin
      if (may_run[1] && pending[1]) next_grant[1] = 1'b1;
      else if (may_run[0] && pending[0]) next_grant[0] = 1'b1;
    end else begin
      if (may_run[0] && pending[0]) next_grant[0] = 1'b1;
      else if (may_run[1] && pending[1]) next_grant[1] = 1'b1;
    end
  end

  assign busy = |grant;

  always_ff @(posedge core_clk) begin
    if (init) begin
      grant <= '0;
    end else if (busy && !unit_done) begin
      // enables dropping abort the unit at once; nmi/error only block the next
      grant <= grant & {channel_control[1][DCS_B_EN], channel_control[0][DCS_B_EN]} &
               {NCH{operation_register[DCS_B_ME]}};
    end else if (busy) begin
      grant <= '0;
    end else begin
      grant <= next_grant;
    end
  end

  always_ff @(posedge core_clk) begin
    if (init) begin
      rr_ch1_first <= 1'b1;
    end else if (busy && unit_done) begin
      rr_ch1_first <= grant[0]; // served channel drops to the bottom
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (init) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        DCS_CTRL0: reg_rdata <= {16'h0000, channel_control[0]};
        DCS_CTRL1: reg_rdata <= {16'h0000, channel_control[1]};
        DCS_VEC0:  reg_rdata <= {24'h000000, end_vector[0]};
        DCS_VEC1:  reg_rdata <= {24'h000000, end_vector[1]};
        DCS_RSEL0: reg_rdata <= {30'h0, req_source[0]};
        DCS_RSEL1: reg_rdata <= {30'h0, req_source[1]};
        DCS_OPER:  reg_rdata <= {28'h0, operation_register};
        DCS_CNT0:  reg_rdata <= {8'h00, transfer_count[0]};
        DCS_CNT1:  reg_rdata <= {8'h00, transfer_count[1]};
        default:   reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_irq_follows: assert property (@(posedge core_clk) disable iff (init)
    transfer_end_irq[0] == (channel_control[0][DCS_B_TE] && channel_control[0][DCS_B_IE]))
    else $error("end interrupt mismatch");
  // watch the registered grant, not the arbiter term it is built from
  chk_grant_needs_enable: assert property (@(posedge core_clk) disable iff (init)
    $rose(grant[0]) |-> $past(may_run[0] && pending[0]))
    else $error("grant without enable");
  chk_te_blocks: assert property (@(posedge core_clk) disable iff (init)
    channel_control[0][DCS_B_TE] |=> !$rose(grant[0]))
    else $error("grant while end flag set");
  chk_nmi_sets: assert property (@(posedge core_clk) disable iff (init)
    nmi |=> operation_register[DCS_B_NMI])
    else $error("nmi flag not set");
  chk_ae_blocks: assert property (@(posedge core_clk) disable iff (init)
    operation_register[DCS_B_AE] |=> (!$rose(grant[0]) && !$rose(grant[1])))
    else $error("grant under address error");
  chk_nmi_blocks: assert property (@(posedge core_clk) disable iff (init)
    operation_register[DCS_B_NMI] |=> (!$rose(grant[0]) && !$rose(grant[1])))
    else $error("grant under nmi flag");
  chk_en_abort: assert property (@(posedge core_clk) disable iff (init)
    !channel_control[1][DCS_B_EN] |=> !grant[1])
    else $error("grant after channel disable");
  // nmi or error must not cut a unit that both enables still allow
  chk_unit_held: assert property (@(posedge core_clk) disable iff (init)
    (grant[1] && !unit_done && channel_control[1][DCS_B_EN] && operation_register[DCS_B_ME]) |=> grant[1])
    else $error("unit cut before it finished");
  chk_me_abort: assert property (@(posedge core_clk) disable iff (init)
    (!operation_register[DCS_B_ME] && !unit_done) |=> grant == '0)
    else $error("grant after master disable");
  chk_count_dec: assert property (@(posedge core_clk) disable iff (init)
    (unit_done && grant[0]) |=> transfer_count[0] == $past(transfer_count[0]) - DCS_CNT_W'(1))
    else $error("count not decremented");
  chk_te_end: assert property (@(posedge core_clk) disable iff (init)
    (unit_done && grant[0] && transfer_count[0] == DCS_CNT_W'(1)) |=> channel_control[0][DCS_B_TE])
    else $error("end flag not set");
  chk_fixed_pri: assert property (@(posedge core_clk) disable iff (init)
    (!operation_register[DCS_B_PRI] && next_grant[1]) |-> !(may_run[0] && pending[0]))
    else $error("fixed priority broken");
endmodule

//--- src/dcs_pkg.sv
// dma channel control/status: shared constants
// assumes a plain register port, one clock, synchronous active-high reset
// How it works
// - detect bit 0 means level sensing of request, 1 means edge sensing
// - polarity bit 0 means low/falling, 1 means high/rising
// - bus-mode bit 0 cycle-steal, 1 burst
// - address-mode bit 0 dual address, 1 single address
// - interrupt enable passes transfer-end flag to the cpu request
// - transfer-end flag sets when the remaining count reaches zero
// - aborts by nmi, address error or enables leave the flag clear
// - transfer-end flag clears only by writing 0 after reading 1
// - enable with transfer-end flag set starts nothing
// - auto-request transfers whenever both enables set and all flags clear
// - external or serial requests transfer only when enabled and flags clear
// - clearing channel enable stops that channel
// - vector holds 8 bits, upper bits read zero, bit 7 written 0
// - source select 00 external, 01 serial rx, 10 serial tx, 11 reserved
// - priority bit 0 fixed ch0 first, 1 round robin ch1 first after reset
// - address error flag set on error blocks all channels
// - nmi and address error flags clear by read 1 then write 0
// - nmi sets its flag, current unit finishes, then stops
// - clearing master enable aborts every channel
// - operation register resets to zero, upper 28 bits read zero
// - each unit decrements the channel remaining count by one
package dcs_pkg;
  localparam int          DCS_AW         = 4;
  localparam logic [3:0]  DCS_CTRL0      = 4'h0;
  localparam logic [3:0]  DCS_CTRL1      = 4'h1;
  localparam logic [3:0]  DCS_VEC0       = 4'h2;
  localparam logic [3:0]  DCS_VEC1       = 4'h3;
  localparam logic [3:0]  DCS_RSEL0      = 4'h4;
  localparam logic [3:0]  DCS_RSEL1      = 4'h5;
  localparam logic [3:0]  DCS_OPER       = 4'h6;
  localparam logic [3:0]  DCS_CNT0       = 4'h7;
  localparam logic [3:0]  DCS_CNT1       = 4'h8;
  localparam int          DCS_B_EN       = 0;
  localparam int          DCS_B_TE       = 1;
  localparam int          DCS_B_IE       = 2;
  localparam int          DCS_B_AMODE    = 3;
  localparam int          DCS_B_BMODE    = 4;
  localparam int          DCS_B_POL      = 5;
  localparam int          DCS_B_DET      = 6;
  localparam int          DCS_B_AUTO     = 9;
  localparam int          DCS_B_ME       = 0;
  localparam int          DCS_B_NMI      = 1;
  localparam int          DCS_B_AE       = 2;
  localparam int          DCS_B_PRI      = 3;
  localparam logic [15:0] DCS_CTRL_RST   = 16'h0000;
  localparam logic [15:0] DCS_CTRL_WMASK = 16'hFFFD;
  localparam logic [7:0]  DCS_VEC_RST    = 8'h00;
  localparam logic [1:0]  DCS_RSEL_RST   = 2'h0;
  localparam logic [3:0]  DCS_OPER_RST   = 4'h0;
  localparam logic [1:0]  DCS_SRC_EXT    = 2'h0;
  localparam logic [1:0]  DCS_SRC_RX     = 2'h1;
  localparam logic [1:0]  DCS_SRC_TX     = 2'h2;
  localparam int          DCS_CNT_W      = 24;
endpackage

//--- src/dcs_req_if.sv
// request path between the control block and the per-channel detector
// assumes both ends run on core_clk
`timescale 1ns/1ps
interface dcs_req_if;
  logic       detect_edge; // edge detection chosen
  logic       polarity;    // high/rising when set
  logic [1:0] source;      // request source select
  logic       auto_mode;   // internal auto request
  logic       take;        // a unit is being taken
  logic       pending;     // request outstanding
  modport ctl (output detect_edge, polarity, source, auto_mode, take, input pending);
  modport det (input detect_edge, polarity, source, auto_mode, take, output pending);
endinterface

//--- src/dcs_req_detect.sv
// per-channel request detector: level or edge, polarity, source select
// assumes inputs are synchronous to core_clk
`timescale 1ns/1ps
module dcs_req_detect
  import dcs_pkg::*;
(
  input  wire logic core_clk,            // system clock
  input  wire logic reset,               // sync reset, active high
  input  wire logic ext_request,         // external request line
  input  wire logic serial_rx_full_req,  // serial receive-full
  input  wire logic serial_tx_empty_req, // serial transmit-empty
  dcs_req_if.det    rq                   // control side
);
  logic raw;
  logic raw_q;
  logic latched;
  logic active;
  logic edge_hit;

  always_comb begin
    case (rq.source)
      DCS_SRC_EXT: raw = ext_request;
      DCS_SRC_RX:  raw = serial_rx_full_req;
      DCS_SRC_TX:  raw = serial_tx_empty_req;
      default:     raw = ~rq.polarity;
    endcase
  end

  // polarity folds the active sense into one form
  assign active   = rq.polarity ? raw : ~raw;
  assign edge_hit = active & ~(rq.polarity ? raw_q : ~raw_q);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      raw_q <= 1'b0;
    end else begin
      raw_q <= raw;
    end
  end

  // an edge is remembered until a unit consumes it; a new edge wins over the take
  always_ff @(posedge core_clk) begin
    if (reset) begin
      latched <= 1'b0;
    end else if (edge_hit) begin
      latched <= 1'b1;
    end else if (rq.take) begin
      latched <= 1'b0;
    end
  end

  assign rq.pending = rq.auto_mode ? 1'b1 :
                      (rq.detect_edge ? latched : active);
endmodule

//--- tb/dcs_dp_model.sv
// datapath stand-in: answers each channel grant with one unit_done pulse
// assumes grant is held until unit_done is seen, except when the control block withdraws it as an enable drops
`timescale 1ns/1ps
module dcs_dp_model (
  input  wire logic       core_clk,  // system clock
  input  wire logic       reset,     // sync reset, active high
  input  wire logic [1:0] grant,     // channel grants from the block
  input  wire logic       slow,      // stretch each unit when set
  output logic            unit_done  // unit finished, destination written
);
  logic [3:0] wait_cnt;

  // a withdrawn grant drops the unit in flight, so no late done can leak out
  always_ff @(posedge core_clk) begin
    if (reset || unit_done || grant == 2'h0) begin
      unit_done <= 1'b0;
      wait_cnt  <= 4'h0;
    end else if (wait_cnt == (slow ? 4'h6 : 4'h1)) begin
      unit_done <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

//--- tb/tb.sv
// register-level bench for the two-channel dma control and status block
// assumes a datapath model answering grants; all inputs change after a rising edge
`timescale 1ns/1ps
module tb;
  import dcs_pkg::*;
  logic              core_clk, reset, standby, reg_wr, reg_rd, nmi, addr_error;
  logic              serial_rx_full_req, serial_tx_empty_req, unit_done, slow;
  logic [DCS_AW-1:0] reg_addr;
  logic [31:0]       reg_wdata, reg_rdata, rv;
  logic [1:0]        ext_request, grant, burst_mode, single_addr, transfer_end_irq;
  logic [7:0]        vec0, vec1;
  int                n_mismatch, cmp_count, cyc, n0, n1, m;
  logic [1:0]        order_q [$];

  dcs_top dut (.core_clk(core_clk), .reset(reset), .standby(standby), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_request(ext_request), .serial_rx_full_req(serial_rx_full_req),
    .serial_tx_empty_req(serial_tx_empty_req), .nmi(nmi), .addr_error(addr_error),
    .unit_done(unit_done), .grant(grant), .burst_mode(burst_mode), .single_addr(single_addr),
    .transfer_end_irq(transfer_end_irq), .vec0(vec0), .vec1(vec1));
  dcs_dp_model far (.core_clk(core_clk), .reset(reset), .grant(grant), .slow(slow),
    .unit_done(unit_done));

  // ----------------------------------------
  // clock, unit log and hang guard
  // ----------------------------------------
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (unit_done && grant[0]) n0++;
    if (unit_done && grant[1]) n1++;
    if (unit_done) order_q.push_back(grant);
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  // ----------------------------------------
  // access and check tasks
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    rd(a, rv);
    chk($sformatf("register %0h", a), rv, e);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wait_irq(input int ch);
    for (int i = 0; i < 400 && transfer_end_irq[ch] !== 1'b1; i++) @(posedge core_clk);
  endtask
  task automatic test_done();
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {core_clk, standby, reg_wr, reg_rd, nmi, addr_error, slow} = '0;
    {reg_addr, reg_wdata} = '0;
    {serial_rx_full_req, serial_tx_empty_req, ext_request} = 4'hF;
    reset = 1'b1;
    cycles(5);
    reset <= 1'b0;
    for (int a = 0; a < 7; a++) rc(a, 32'h0);
    rc(4'hF, 32'h0);
    wr(DCS_CTRL0, 32'hFFFFFFFF);
    rc(DCS_CTRL0, 32'h0000FFFD);
    chk("burst_mode", burst_mode, 2'h1);
    chk("single_addr", single_addr, 2'h1);
    rc(DCS_CTRL1, 32'h0);
    wr(DCS_CTRL0, 32'h0);
    wr(DCS_VEC1, 32'hFFFFFF7F);
    rc(DCS_VEC1, 32'h7F);
    chk("vec", {vec1, vec0}, 16'h7F00);
    for (int s = 2; s >= 0; s--) begin
      wr(DCS_RSEL0, 32'hFFFFFFFC | s);
      rc(DCS_RSEL0, s);
    end
    wr(DCS_OPER, 32'hFFFFFFFF);
    rc(DCS_OPER, 32'h9);
    // auto request on channel 0, three units then a normal end
    wr(DCS_OPER, 32'h0);
    wr(DCS_CNT0, 32'h3);
    wr(DCS_CTRL0, 32'h205);
    wr(DCS_OPER, 32'h1);
    wait_irq(0);
    chk("units ch0", n0, 3);
    rc(DCS_CNT0, 32'h0);
    rc(DCS_CTRL0, 32'h207);
    chk("end irq", transfer_end_irq, 2'h1);
    wr(DCS_CNT0, 32'h2);
    wr(DCS_CTRL0, 32'h207);
    wr(DCS_CTRL0, 32'h205);
    cycles(10);
    chk("units held", n0, 3);
    rc(DCS_CTRL0, 32'h207);
    wr(DCS_CTRL0, 32'h205);
    cycles(2);
    chk("irq dropped", transfer_end_irq, 2'h0);
    wait_irq(0);
    chk("units again", n0, 5);
    wr(DCS_CTRL0, 32'h201);
    cycles(1);
    chk("irq masked", transfer_end_irq, 2'h0);
    rc(DCS_CTRL0, 32'h203);
    wr(DCS_CTRL0, 32'h0);
    // external request detection on channel 1, slow datapath
    slow <= 1'b1;
    wr(DCS_CNT1, 32'hFFF);
    wr(DCS_CTRL1, 32'h01);
    cycles(10);
    chk("low level idle", n1, 0);
    ext_request <= 2'h1;
    cycles(30);
    chk("low level runs", n1 != 0, 1);
    wr(DCS_CTRL1, 32'h21);
    cycles(10);
    m = n1;
    cycles(20);
    chk("high level idle", n1, m);
    wr(DCS_CTRL1, 32'h41);
    cycles(10);
    m = n1;
    ext_request <= 2'h3;
    cycles(10);
    ext_request <= 2'h1;
    cycles(20);
    chk("one fall", n1, m + 1);
    wr(DCS_CTRL1, 32'h61);
    m = n1;
    ext_request <= 2'h3;
    cycles(20);
    ext_request <= 2'h1;
    cycles(20);
    chk("one rise", n1, m + 1);
    wr(DCS_CTRL1, 32'h01);
    cycles(3);
    wr(DCS_CTRL1, 32'h0);
    cycles(2);
    chk("enable cleared", grant, 2'h0);
    // serial sources: source changed only while disabled, falling edge detect
    // code 3 is reserved and must select no request at all
    for (int s = 1; s < 4; s++) begin
      serial_rx_full_req  <= 1'b1;
      serial_tx_empty_req <= 1'b1;
      wr(DCS_RSEL1, s);
      wr(DCS_CTRL1, 32'h41);
      m = n1;
      if (s == 1) serial_tx_empty_req <= 1'b0;
      else serial_rx_full_req <= 1'b0;
      cycles(15);
      serial_rx_full_req  <= 1'b0;
      serial_tx_empty_req <= 1'b0;
      cycles(20);
      chk("serial unit", n1, m + (s < 3));
      wr(DCS_CTRL1, 32'h0);
    end
    // nmi and address error stop the channel until cleared
    wr(DCS_RSEL1, 32'h0);
    for (int f = 0; f < 2; f++) begin
      wr(DCS_OPER, 32'h1);
      wr(DCS_CTRL1, 32'h01);
      cycles(5);
      nmi        <= (f == 0);
      addr_error <= (f == 1);
      @(posedge core_clk);
      nmi        <= 1'b0;
      addr_error <= 1'b0;
      wr(DCS_OPER, 32'h1);
      cycles(12);
      m = n1;
      cycles(20);
      chk("flag blocks", n1, m);
      rc(DCS_CTRL1, 32'h01);
      rc(DCS_OPER, 32'h1 | (32'h2 << f));
      wr(DCS_OPER, 32'h1);
      cycles(20);
      chk("flag cleared", n1 != m, 1);
    end
    wr(DCS_OPER, 32'h0);
    cycles(2);
    chk("master cleared", grant, 2'h0);
    // standby initialises, then priority order with both channels on auto
    slow    <= 1'b0;
    standby <= 1'b1;
    @(posedge core_clk);
    standby <= 1'b0;
    for (int a = 0; a < 7; a++) rc(a, 32'h0);
    for (int p = 0; p < 2; p++) begin
      wr(DCS_OPER, 32'h0);
      wr(DCS_CNT0, 32'h3);
      wr(DCS_CNT1, 32'h3);
      for (int c = 0; c < 2; c++) begin
        rd(c, rv);
        wr(c, 32'h201);
      end
      order_q.delete();
      wr(DCS_OPER, p ? 32'h1 : 32'h9);
      cycles(80);
      chk("unit total", order_q.size(), 6);
      for (int i = 0; i < 4 && i < order_q.size(); i++)
        chk("grant order", order_q[i], p ? (i < 3 ? 2'h1 : 2'h2) : (i[0] ? 2'h1 : 2'h2));
    end
    test_done();
  end
endmodule
